// file: bench/svw_host_model.sv
module svw_host_model #(
  parameter int unsigned NVW_CYC = 30
) (
  // Clock
  input wire logic hclk,
  // Toward the device
  output svw_pkg::svw_pins_t pins,
  output svw_pkg::svw_bus_ev_t bus_ev
);
  timeunit 1ns;
  timeprecision 100ps;
  import svw_pkg::*;
  initial begin
    pins = '0;
    pins.manual_reset_in_n = 1'b1;
    bus_ev = '0;
  end
  // Ten cycles is the 1 us minimum width
  task automatic kick;
    @(posedge hclk) pins.wdt_restart <= 1'b1;
    repeat (10) @(posedge hclk);
    pins.wdt_restart <= 1'b0;
  endtask
  task automatic man_press(input int n);
    @(posedge hclk) pins.manual_reset_in_n <= 1'b0;
    repeat (n) @(posedge hclk);
    pins.manual_reset_in_n <= 1'b1;
  endtask
  // Select level is flipped between clocks so stale values never look valid
  task automatic frame(input logic m, input logic stp, input logic w);
    @(posedge hclk) bus_ev.start_cond <= 1'b1;
    @(posedge hclk) bus_ev.start_cond <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge hclk);
      bus_ev.scl_rise <= 1'b1;
      bus_ev.sel_match <= m;
      @(posedge hclk);
      bus_ev.scl_rise <= 1'b0;
      bus_ev.sel_match <= ~m;
    end
    if (stp) begin
      @(posedge hclk);
      bus_ev.stop_cond <= 1'b1;
      bus_ev.wr_seq_valid <= w;
      @(posedge hclk);
      bus_ev.stop_cond <= 1'b0;
      bus_ev.wr_seq_valid <= ~w;
    end
  endtask
  task automatic nv_wait;
    repeat (NVW_CYC) @(posedge hclk);
  endtask
endmodule

// file: bench/svw_top_asserts.sv
module svw_top_asserts #(
  parameter int unsigned POR_CYC_0 = 40,
  parameter int unsigned WRST_LONG_CYC = 50,
  parameter int unsigned WRST_SHORT_CYC = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs seen by the block
  input wire svw_pkg::svw_pins_t pins,
  input wire svw_pkg::svw_bus_ev_t bus_ev,
  // Supervisor outputs
  input wire logic sys_reset_out,
  input wire logic vcc_low_warning,
  input wire logic second_supply_fail,
  input wire logic third_supply_fail,
  input wire logic wdt_timeout_out,
  input wire logic dev_active,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import svw_pkg::*;
  int unsigned por_cnt;
  int unsigned timeout_len;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************
  // Helper counters
  // ****************
  // Async clear so a mid-run reset restarts both counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_cnt <= 0;
      timeout_len <= 0;
    end else begin
      por_cnt <= (por_cnt < POR_CYC_0) ? por_cnt + 1 : por_cnt;
      timeout_len <= wdt_timeout_out ? timeout_len + 1 : 0;
    end
  end
  // ****************
  // Properties
  // ****************
  por_hold_a: assert property (por_cnt + 1 < POR_CYC_0 |-> sys_reset_out)
    else $error("reset released early");
  low_detect_a: assert property ($rose(pins.main_below_trip)
    ##1 (pins.main_below_trip)[*3] |-> ##[0:200] (vcc_low_warning && sys_reset_out))
    else $error("low supply missed");
  warn_lead_a: assert property ($rose(vcc_low_warning) && !sys_reset_out
    |-> (!sys_reset_out)[*4] ##[1:2] sys_reset_out) else $error("warning lead wrong");
  v2_fail_a: assert property ($rose(pins.second_supply_sense)
    ##1 (pins.second_supply_sense)[*3] |-> ##[0:200] second_supply_fail)
    else $error("second fail missed");
  v3_fail_a: assert property ($rose(pins.third_supply_sense)
    ##1 (pins.third_supply_sense)[*3] |-> ##[0:200] third_supply_fail)
    else $error("third fail missed");
  glitch_drop_a: assert property (!second_supply_fail
    ##1 $rose(pins.second_supply_sense) ##1 (!pins.second_supply_sense)[*4]
    |-> !second_supply_fail) else $error("glitch passed");
  man_delay_a: assert property ($fell(pins.manual_reset_in_n) && !sys_reset_out
    |-> (!sys_reset_out)[*5]) else $error("manual reset too soon");
  man_assert_a: assert property ($fell(pins.manual_reset_in_n)
    ##1 (!pins.manual_reset_in_n)[*7] |-> ##[0:20] sys_reset_out)
    else $error("manual reset missed");
  timeout_len_a: assert property ($fell(wdt_timeout_out)
    |-> timeout_len == WRST_LONG_CYC || timeout_len == WRST_SHORT_CYC)
    else $error("timeout length");
  stop_idle_a: assert property (bus_ev.stop_cond && !bus_ev.wr_seq_valid && dev_active
    |-> ##[1:3] !dev_active) else $error("no standby after stop");
  start_wake_a: assert property (bus_ev.start_cond |=> dev_active)
    else $error("start did not wake");
  cover property ($rose(wdt_timeout_out));
  cover property ($rose(vcc_low_warning));
  cover property (bus_ev.stop_cond && bus_ev.wr_seq_valid);
  cover property ($rose(irq));
endmodule

bind svw_top svw_top_asserts #(.POR_CYC_0(POR_CYC_0), .WRST_LONG_CYC(WRST_LONG_CYC),
  .WRST_SHORT_CYC(WRST_SHORT_CYC)) chk_u (.hclk(hclk), .hresetn(hresetn), .pins(pins),
  .bus_ev(bus_ev), .sys_reset_out(sys_reset_out), .vcc_low_warning(vcc_low_warning),
  .second_supply_fail(second_supply_fail), .third_supply_fail(third_supply_fail),
  .wdt_timeout_out(wdt_timeout_out), .dev_active(dev_active), .irq(irq));

// file: bench/svw_top_bench.sv
module svw_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import svw_pkg::*;
  localparam int unsigned PT[4] = '{40, 50, 60, 70};
  localparam int unsigned WT[3] = '{400, 300, 200};
  localparam int unsigned HT[3] = '{50, 50, 20};
  localparam int unsigned NV = 30;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sys_reset_out, vcc_low_warning, second_supply_fail;
  logic third_supply_fail, wdt_timeout_out, dev_active, irq;
  svw_pins_t pins;
  svw_bus_ev_t bus_ev;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 hclk = ~hclk;
  svw_host_model #(.NVW_CYC(NV)) host_u (.hclk(hclk), .pins(pins), .bus_ev(bus_ev));
  svw_top #(.POR_CYC_0(PT[0]), .POR_CYC_1(PT[1]), .POR_CYC_2(PT[2]), .POR_CYC_3(PT[3]),
    .WDT_CYC_0(WT[0]), .WDT_CYC_1(WT[1]), .WDT_CYC_2(WT[2]), .WRST_LONG_CYC(HT[0]),
    .WRST_SHORT_CYC(HT[2]), .NVW_CYC(NV)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(pins), .bus_ev(bus_ev),
    .sys_reset_out(sys_reset_out), .vcc_low_warning(vcc_low_warning),
    .second_supply_fail(second_supply_fail), .third_supply_fail(third_supply_fail),
    .wdt_timeout_out(wdt_timeout_out), .dev_active(dev_active), .irq(irq));
  // ****************
  // Shared tasks
  // ****************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Run is near 2500 cycles, so this only trips on a hang
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_span(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch at %0t: span %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  function automatic logic [31:0] ra(input logic [5:0] i);
    return {24'h0, i, 2'h0};
  endfunction
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    int n;
    n = 0;
    while (sys_reset_out !== 1'b0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    chk_span(n, PT[0] - 1, PT[0] + 2);
    bus(ra(IDX_CTRL), 1'b0, 32'h0);
    chk_word(rd, 32'h0);
    bus(ra(IDX_MASK), 1'b0, 32'h0);
    chk_word(rd, 32'h0);
    bus(ra(IDX_STATE), 1'b0, 32'h0);
    chk_word({29'h0, rd[10:8]}, 32'h0);
    bus(32'hf0, 1'b0, 32'h0);
    chk_word(rd, 32'h0);
    chk_word({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_por;
    int n;
    for (int k = 0; k < 4; k++) begin
      bus(ra(IDX_CTRL), 1'b1, 32'hc | 32'(k));
      @(posedge hclk) host_u.pins.main_below_trip <= 1'b1;
      repeat (30) @(posedge hclk);
      chk_word({30'h0, vcc_low_warning, sys_reset_out}, 32'h3);
      host_u.pins.main_below_trip <= 1'b0;
      n = 0;
      while (sys_reset_out !== 1'b0 && n < 500) begin
        @(posedge hclk);
        n++;
      end
      chk_span(n, PT[k], PT[k] + 8);
    end
    $display("test por done");
  endtask
  task automatic t_wdt;
    int n;
    for (int k = 0; k < 4; k++) begin
      bus(ra(IDX_CTRL), 1'b1, 32'(k) << 2);
      host_u.kick();
      n = 0;
      while (wdt_timeout_out !== 1'b1 && n < 600) begin
        @(posedge hclk);
        n++;
      end
      if (k == 3) begin
        chk_span(n, 600, 600);
      end else begin
        chk_span(n, WT[k] - 12, WT[k] - 2);
        n = 0;
        while (wdt_timeout_out === 1'b1 && n < 100) begin
          @(posedge hclk);
          n++;
        end
        chk_span(n, HT[k], HT[k] + 1);
      end
    end
    $display("test wdt done");
  endtask
  task automatic t_mon;
    bus(ra(IDX_STATUS), 1'b0, 32'h0);
    bus(ra(IDX_MASK), 1'b1, 32'h1 << EV_V2);
    @(posedge hclk) host_u.pins.second_supply_sense <= 1'b1;
    @(posedge hclk) host_u.pins.second_supply_sense <= 1'b0;
    repeat (10) @(posedge hclk);
    chk_word({31'h0, second_supply_fail}, 32'h0);
    host_u.pins.second_supply_sense <= 1'b1;
    repeat (30) @(posedge hclk);
    chk_word({30'h0, second_supply_fail, irq}, 32'h3);
    host_u.pins.second_supply_sense <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(ra(IDX_STATUS), 1'b0, 32'h0);
    chk_word(rd & (32'h1 << EV_V2), 32'h1 << EV_V2);
    repeat (3) @(posedge hclk);
    chk_word({31'h0, irq}, 32'h0);
    bus(ra(IDX_MASK), 1'b1, 32'h0);
    @(posedge hclk) host_u.pins.third_supply_sense <= 1'b1;
    repeat (30) @(posedge hclk);
    chk_word({30'h0, third_supply_fail, irq}, 32'h2);
    host_u.pins.third_supply_sense <= 1'b0;
    bus(ra(IDX_STATUS), 1'b0, 32'h0);
    chk_word(rd & (32'h1 << EV_V3), 32'h1 << EV_V3);
    $display("test monitors done");
  endtask
  task automatic t_man;
    int n;
    n = 0;
    fork
      host_u.man_press(60);
      while (sys_reset_out !== 1'b1 && n < 50) begin
        @(posedge hclk);
        n++;
      end
    join
    chk_span(n, 5, 12);
    repeat (10) @(posedge hclk);
    chk_word({31'h0, sys_reset_out}, 32'h0);
    $display("test manual done");
  endtask
  task automatic t_ser;
    int n;
    host_u.frame(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge hclk);
    chk_word({31'h0, dev_active}, 32'h0);
    host_u.frame(1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge hclk);
    chk_word({31'h0, dev_active}, 32'h0);
    bus(ra(IDX_CTRL), 1'b1, 32'h1c);
    @(posedge hclk) host_u.pins.write_protect <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(ra(IDX_CTRL), 1'b1, 32'h0);
    bus(ra(IDX_CTRL), 1'b0, 32'h0);
    chk_word(rd, 32'h1c);
    host_u.frame(1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge hclk);
    chk_word({31'h0, dev_active}, 32'h0);
    host_u.pins.write_protect <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(ra(IDX_STATUS), 1'b0, 32'h0);
    host_u.frame(1'b1, 1'b1, 1'b1);
    n = 0;
    while (dev_active === 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk_span(n, NV - 3, NV + 2);
    host_u.nv_wait();
    bus(ra(IDX_STATUS), 1'b0, 32'h0);
    chk_word(rd & (32'h1 << EV_NVW), 32'h1 << EV_NVW);
    $display("test serial done");
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_por();
    t_wdt();
    t_mon();
    t_man();
    t_ser();
    tally_and_finish();
  end
endmodule

// file: hdl/svw_pkg.sv
package svw_pkg;

  // ****************************************
  // Clock and times
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned POR_T0_MS = 50;
  localparam int unsigned POR_T1_MS = 200;
  localparam int unsigned POR_T2_MS = 400;
  localparam int unsigned POR_T3_MS = 800;
  localparam int unsigned WDT_T0_MS = 1400;
  localparam int unsigned WDT_T1_MS = 200;
  localparam int unsigned WDT_T2_MS = 25;
  localparam int unsigned WRST_LONG_MS = 200;
  localparam int unsigned WRST_SHORT_MS = 25;
  localparam int unsigned NVW_T_MS = 5;
  localparam int unsigned STBY_T_NS = 200;
  localparam int unsigned LR_T_NS = 500;
  localparam int unsigned MD_T_NS = 500;
  localparam int unsigned GLITCH_T_NS = 50;
  localparam int unsigned RPD_T_US = 20;
  localparam int unsigned POR_CYC_0 = POR_T0_MS * CYC_PER_MS;
  localparam int unsigned POR_CYC_1 = POR_T1_MS * CYC_PER_MS;
  localparam int unsigned POR_CYC_2 = POR_T2_MS * CYC_PER_MS;
  localparam int unsigned POR_CYC_3 = POR_T3_MS * CYC_PER_MS;
  localparam int unsigned WDT_CYC_0 = WDT_T0_MS * CYC_PER_MS;
  localparam int unsigned WDT_CYC_1 = WDT_T1_MS * CYC_PER_MS;
  localparam int unsigned WDT_CYC_2 = WDT_T2_MS * CYC_PER_MS;
  localparam int unsigned WRST_LONG_CYC = WRST_LONG_MS * CYC_PER_MS;
  localparam int unsigned WRST_SHORT_CYC = WRST_SHORT_MS * CYC_PER_MS;
  localparam int unsigned NVW_CYC = NVW_T_MS * CYC_PER_MS;
  localparam logic [23:0] STBY_CYC = 24'(STBY_T_NS / CLK_PERIOD_NS);
  localparam logic [7:0] LR_CYC = 8'(LR_T_NS / CLK_PERIOD_NS);
  localparam logic [3:0] MD_CYC = 4'((MD_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned GLITCH_CYC = (GLITCH_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RPD_CYC = RPD_T_US * CYC_PER_US;
  localparam logic [3:0] SEL_SCL_CNT = 4'h9;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_MASK = 6'h02;
  localparam logic [5:0] IDX_STATE = 6'h03;
  localparam int unsigned CTRL_POR_LSB = 0;
  localparam int unsigned CTRL_WDT_LSB = 2;
  localparam int unsigned CTRL_LATCH_BIT = 4;
  localparam logic [1:0] POR_SEL_RST = 2'h0;
  localparam logic [1:0] WDT_SEL_RST = 2'h0;
  localparam logic [1:0] WDT_SEL_OFF = 2'h3;
  localparam logic [1:0] WDT_SEL_FAST = 2'h2;
  localparam logic [5:0] MASK_RST = 6'h00;

  // Status bit positions
  localparam int unsigned EV_WDT = 0;
  localparam int unsigned EV_LOW = 1;
  localparam int unsigned EV_V2 = 2;
  localparam int unsigned EV_V3 = 3;
  localparam int unsigned EV_MAN = 4;
  localparam int unsigned EV_NVW = 5;

  // Filtered input positions
  // Follow the pin struct: its first member is the top bit
  localparam int unsigned IN_MAIN = 5;
  localparam int unsigned IN_V2 = 4;
  localparam int unsigned IN_V3 = 3;
  localparam int unsigned IN_MAN = 2;
  localparam int unsigned IN_KICK = 1;
  localparam int unsigned IN_WP = 0;
  localparam int unsigned N_IN = 6;
  // Idle pin levels: only the manual reset pin rests high
  localparam logic [5:0] FILT_RST = 6'h04;

  typedef enum logic [2:0] {SS_STBY, SS_SEL, SS_ACT, SS_STOP, SS_NVWR} svw_ser_t;

  typedef struct packed {
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic sel_match;
    logic wr_seq_valid;
  } svw_bus_ev_t;

  typedef struct packed {
    logic main_below_trip;
    logic second_supply_sense;
    logic third_supply_sense;
    logic manual_reset_in_n;
    logic wdt_restart;
    logic write_protect;
  } svw_pins_t;

endpackage

// file: hdl/svw_top.sv
module svw_top #(
  parameter int unsigned POR_CYC_0 = svw_pkg::POR_CYC_0,
  parameter int unsigned POR_CYC_1 = svw_pkg::POR_CYC_1,
  parameter int unsigned POR_CYC_2 = svw_pkg::POR_CYC_2,
  parameter int unsigned POR_CYC_3 = svw_pkg::POR_CYC_3,
  parameter int unsigned WDT_CYC_0 = svw_pkg::WDT_CYC_0,
  parameter int unsigned WDT_CYC_1 = svw_pkg::WDT_CYC_1,
  parameter int unsigned WDT_CYC_2 = svw_pkg::WDT_CYC_2,
  parameter int unsigned WRST_LONG_CYC = svw_pkg::WRST_LONG_CYC,
  parameter int unsigned WRST_SHORT_CYC = svw_pkg::WRST_SHORT_CYC,
  parameter int unsigned NVW_CYC = svw_pkg::NVW_CYC
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Monitor and control pins
  input wire svw_pkg::svw_pins_t pins,
  // Two-wire front end events
  input wire svw_pkg::svw_bus_ev_t bus_ev,
  // Supervisor outputs
  output logic sys_reset_out,
  output logic vcc_low_warning,
  output logic second_supply_fail,
  output logic third_supply_fail,
  output logic wdt_timeout_out,
  output logic dev_active,
  output logic irq
);
  import svw_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [N_IN-1:0] filt;
    logic [N_IN-1:0] prev;
    logic [1:0] por_sel;
    logic [1:0] wdt_sel;
    logic write_enable_latch;
    logic [5:0] status;
    logic [5:0] mask;
    logic por_busy;
    logic [23:0] por_cnt;
    logic [23:0] wdt_cnt;
    logic [23:0] wrst_cnt;
    logic wdt_out;
    logic kick_q;
    logic [7:0] low_cnt;
    logic low_warn;
    logic low_rst;
    logic [3:0] man_cnt;
    logic man_rst;
    logic v2f;
    logic v3f;
    svw_ser_t ser;
    logic [3:0] scl_cnt;
    logic [23:0] act_cnt;
    logic rst_out;
    logic active;
    logic irq;
    logic rdy;
    logic wr_pend;
    logic [5:0] wr_idx;
    logic [31:0] rdata;
  } svw_st_t;

  svw_st_t s;
  svw_st_t next_s;
  logic [N_IN-1:0] raw;
  logic [N_IN-1:0] stable;

  assign raw = pins;

  function automatic logic [23:0] por_len(input logic [1:0] sel);
    case (sel)
      2'h0: por_len = 24'(POR_CYC_0);
      2'h1: por_len = 24'(POR_CYC_1);
      2'h2: por_len = 24'(POR_CYC_2);
      default: por_len = 24'(POR_CYC_3);
    endcase
  endfunction

  function automatic logic [23:0] wdt_len(input logic [1:0] sel);
    case (sel)
      2'h0: wdt_len = 24'(WDT_CYC_0);
      2'h1: wdt_len = 24'(WDT_CYC_1);
      default: wdt_len = 24'(WDT_CYC_2);
    endcase
  endfunction

  // ****************************************
  // Glitch filter
  // ****************************************
  // A level must repeat on consecutive samples before it is believed
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_filt
      if (GLITCH_CYC > 0) begin : g_on
        assign stable[gi] = (raw[gi] == s.prev[gi]);
      end else begin : g_off
        assign stable[gi] = 1'b1;
      end
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic acc;
    logic [5:0] idx;
    logic [5:0] ev;
    logic wp;
    logic kick_edge;
    logic rd_clr;
    acc = 1'b0;
    idx = 6'h00;
    ev = 6'h00;
    wp = 1'b0;
    kick_edge = 1'b0;
    rd_clr = 1'b0;
    next_s = s;
    if (clk_en) begin
      next_s.prev = raw;
      for (int i = 0; i < N_IN; i++) begin
        if (stable[i]) begin
          next_s.filt[i] = raw[i];
        end
      end
      wp = s.filt[IN_WP];

      // Bus slave
      next_s.rdy = 1'b1;
      acc = hsel && htrans[1] && hready;
      idx = haddr[7:2];
      next_s.wr_pend = acc && hwrite;
      if (acc) begin
        next_s.wr_idx = idx;
      end
      if (acc && !hwrite) begin
        case (idx)
          IDX_CTRL: next_s.rdata = {27'h0, s.write_enable_latch, s.wdt_sel, s.por_sel};
          IDX_STATUS: next_s.rdata = {26'h0, s.status};
          IDX_MASK: next_s.rdata = {26'h0, s.mask};
          IDX_STATE: next_s.rdata = {20'h0, 1'(s.ser != SS_STBY), s.ser, s.wdt_out,
                                     s.v3f, s.v2f, s.low_warn, s.rst_out, s.por_busy,
                                     s.man_rst, s.low_rst};
          default: next_s.rdata = 32'h0000_0000;
        endcase
        rd_clr = (idx == IDX_STATUS);
      end
      if (s.wr_pend && !wp) begin
        case (s.wr_idx)
          IDX_CTRL: begin
            next_s.por_sel = hwdata[CTRL_POR_LSB +: 2];
            next_s.wdt_sel = hwdata[CTRL_WDT_LSB +: 2];
            next_s.write_enable_latch = hwdata[CTRL_LATCH_BIT];
          end
          IDX_MASK: next_s.mask = hwdata[5:0];
          default: ;
        endcase
      end

      // Power-on and recovery reset
      if (s.por_busy) begin
        if (s.por_cnt >= por_len(s.por_sel) - 24'h1) begin
          next_s.por_busy = 1'b0;
        end else begin
          next_s.por_cnt = s.por_cnt + 24'h1;
        end
      end

      // Main supply low-line
      if (s.filt[IN_MAIN]) begin
        next_s.low_warn = 1'b1;
        if (!s.low_warn) begin
          ev[EV_LOW] = 1'b1;
        end
        if (s.low_warn && !s.low_rst) begin
          if (s.low_cnt >= LR_CYC - 8'h1) begin
            next_s.low_rst = 1'b1;
          end else begin
            next_s.low_cnt = s.low_cnt + 8'h1;
          end
        end
      end else begin
        next_s.low_warn = 1'b0;
        next_s.low_cnt = 8'h00;
        if (s.low_rst) begin
          // Supply is back: hold reset for the power-on delay again
          next_s.low_rst = 1'b0;
          next_s.por_busy = 1'b1;
          next_s.por_cnt = 24'h0;
        end
      end

      // Second and third supplies
      next_s.v2f = s.filt[IN_V2];
      next_s.v3f = s.filt[IN_V3];
      ev[EV_V2] = s.filt[IN_V2] && !s.v2f;
      ev[EV_V3] = s.filt[IN_V3] && !s.v3f;

      // Manual reset
      if (!s.filt[IN_MAN]) begin
        if (s.man_cnt >= MD_CYC - 4'h1) begin
          next_s.man_rst = 1'b1;
          ev[EV_MAN] = !s.man_rst;
        end else begin
          next_s.man_cnt = s.man_cnt + 4'h1;
        end
      end else begin
        next_s.man_cnt = 4'h0;
        next_s.man_rst = 1'b0;
      end

      // Watchdog
      next_s.kick_q = s.filt[IN_KICK];
      kick_edge = s.filt[IN_KICK] && !s.kick_q;
      if (s.wdt_out) begin
        if (s.wrst_cnt == 24'h1) begin
          next_s.wdt_out = 1'b0;
          next_s.wdt_cnt = 24'h0;
        end
        next_s.wrst_cnt = s.wrst_cnt - 24'h1;
      end else if (s.wdt_sel == WDT_SEL_OFF || s.por_busy) begin
        next_s.wdt_cnt = 24'h0;
      end else if (kick_edge) begin
        next_s.wdt_cnt = 24'h0;
      end else if (s.wdt_cnt >= wdt_len(s.wdt_sel) - 24'h1) begin
        next_s.wdt_out = 1'b1;
        ev[EV_WDT] = 1'b1;
        if (s.wdt_sel == WDT_SEL_FAST) begin
          next_s.wrst_cnt = 24'(WRST_SHORT_CYC);
        end else begin
          next_s.wrst_cnt = 24'(WRST_LONG_CYC);
        end
      end else begin
        next_s.wdt_cnt = s.wdt_cnt + 24'h1;
      end

      // Serial slave active/standby
      case (s.ser)
        SS_STBY, SS_ACT, SS_STOP, SS_SEL: begin
          if (bus_ev.start_cond) begin
            next_s.ser = SS_SEL;
            next_s.scl_cnt = 4'h0;
          end else if (bus_ev.stop_cond && s.ser != SS_STBY) begin
            if (bus_ev.wr_seq_valid && s.write_enable_latch && !wp) begin
              next_s.ser = SS_NVWR;
              next_s.act_cnt = 24'(NVW_CYC);
            end else begin
              next_s.ser = SS_STOP;
              next_s.act_cnt = STBY_CYC;
            end
          end else if (s.ser == SS_SEL && bus_ev.scl_rise) begin
            next_s.scl_cnt = s.scl_cnt + 4'h1;
            if (s.scl_cnt == SEL_SCL_CNT - 4'h1) begin
              next_s.ser = bus_ev.sel_match ? SS_ACT : SS_STBY;
            end
          end else if (s.ser == SS_STOP) begin
            if (s.act_cnt <= 24'h1) begin
              next_s.ser = SS_STBY;
            end
            next_s.act_cnt = s.act_cnt - 24'h1;
          end
        end
        SS_NVWR: begin
          // Busy write ignores the bus; host polls or waits
          if (s.act_cnt <= 24'h1) begin
            next_s.ser = SS_STBY;
            ev[EV_NVW] = 1'b1;
          end
          next_s.act_cnt = s.act_cnt - 24'h1;
        end
        default: next_s.ser = SS_STBY;
      endcase

      // Outputs and interrupt
      next_s.rst_out = next_s.por_busy || next_s.low_rst || next_s.man_rst;
      next_s.active = (next_s.ser != SS_STBY);
      next_s.status = (rd_clr ? 6'h00 : s.status) | ev;
      next_s.irq = |(next_s.status & s.mask);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.filt <= FILT_RST;
      s.prev <= FILT_RST;
      s.por_sel <= POR_SEL_RST;
      s.wdt_sel <= WDT_SEL_RST;
      s.mask <= MASK_RST;
      s.write_enable_latch <= 1'b0;
      s.ser <= SS_STBY;
      s.por_busy <= 1'b1;
      s.rst_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.rdy;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign sys_reset_out = s.rst_out;
  assign vcc_low_warning = s.low_warn;
  assign second_supply_fail = s.v2f;
  assign third_supply_fail = s.v3f;
  assign wdt_timeout_out = s.wdt_out;
  assign dev_active = s.active;
  assign irq = s.irq;

endmodule
